// ===== include/los_pkg.sv
// Purpose: constants and types shared by the link oam sublayer status block
// Assumes: 32-bit ahb-lite register bus, byte offsets
// Notes:   one word per register
package los_pkg;

  // register byte offsets
  localparam logic [7:0] LOS_OFF_CTRL   = 8'h00;
  localparam logic [7:0] LOS_OFF_STATUS = 8'h04;
  localparam logic [7:0] LOS_OFF_MTU    = 8'h08;
  localparam logic [7:0] LOS_OFF_OUI    = 8'h0c;
  localparam logic [7:0] LOS_OFF_REV    = 8'h10;
  localparam logic [7:0] LOS_OFF_PEER   = 8'h14;
  localparam logic [7:0] LOS_OFF_CNT    = 8'h18;

  // control register fields
  localparam int LOS_CTL_MODE   = 0;
  localparam int LOS_CTL_LB     = 1;
  localparam int LOS_CTL_LM     = 2;
  localparam int LOS_CTL_MIB    = 3;
  localparam int LOS_CTL_MUX    = 4;
  localparam int LOS_CTL_PAR    = 5;
  localparam int LOS_CTL_PERM   = 8;
  localparam int LOS_CTL_DISC   = 12;

  // reset values
  localparam logic [31:0] LOS_CTRL_RST  = 32'h0000_0300;
  localparam logic [15:0] LOS_MTU_RST   = 16'h05dc;
  // arbitrary vendor identifier value
  localparam logic [23:0] LOS_OUI_RST   = 24'h00_00_01;
  localparam logic [15:0] LOS_PEER_RST  = 16'hffff;

  // fifo shape
  localparam int LOS_FIFO_W = 10;
  localparam int LOS_FIFO_D = 8;

  typedef enum logic [0:0] {
    LOS_MUX_FWD = 1'b0,
    LOS_MUX_DIS = 1'b1
  } los_mux_t;

  typedef enum logic [1:0] {
    LOS_PAR_FWD = 2'b00,
    LOS_PAR_LB  = 2'b01,
    LOS_PAR_DIS = 2'b10
  } los_par_t;

  typedef enum logic [1:0] {
    LOS_PERM_LF   = 2'b00,
    LOS_PERM_RX   = 2'b01,
    LOS_PERM_INFO = 2'b10,
    LOS_PERM_ANY  = 2'b11
  } los_perm_t;

  typedef enum logic [2:0] {
    LOS_DSC_FAULT   = 3'b000,
    LOS_DSC_ACTIVE  = 3'b001,
    LOS_DSC_PASSIVE = 3'b010,
    LOS_DSC_SLR     = 3'b011,
    LOS_DSC_SLR_OK  = 3'b100,
    LOS_DSC_ANY     = 3'b101
  } los_disc_t;

endpackage

// ===== rtl/los_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes:   read data come from a register
`timescale 1ns/1ns
module los_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          ov_q;
  logic [W-1:0]  od_q;
  logic          mem_pop;
  logic          push;
  logic          pop;

  // output register refills whenever empty or being taken
  assign mem_pop  = (cnt_q != '0) && (!ov_q || out_ready);
  assign push     = in_valid && in_ready;
  assign pop      = mem_pop;
  // the output register counts toward the depth
  assign in_ready = (((AW+1)'(ov_q) + cnt_q) != (AW+1)'(D));
  assign out_valid = ov_q;
  assign out_data  = od_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end else begin
      if (push) begin
        wp_q <= AW'((32'(wp_q) + 1) % D);
      end
      if (pop) begin
        rp_q <= AW'((32'(rp_q) + 1) % D);
        od_q <= mem[rp_q];
        ov_q <= 1'b1;
      end else if (out_ready) begin
        ov_q <= 1'b0;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  chk_fifo_depth: assert property (@(posedge clk) disable iff (!rst_n)
    ((AW+1)'(ov_q) + cnt_q) <= (AW+1)'(D))
    else $error("fifo holds more than its depth");
endmodule // los_fifo

// ===== rtl/los_top.sv
// Purpose: link oam sublayer status and non-oampdu frame steering
// Assumes: 25 mhz hclk, frame words are synchronous, ahb-lite slave
// Notes:   frame words carry sof/eof flags with 8 data bits
//
// Summary of operation
// - mux forwarding passes non-oampdu frames down; discarding drops those from the higher sublayer
// - parser forwarding delivers received non-oampdu frames upward
// - parser loopback returns received non-oampdu frames to the lower side
// - parser discarding drops received non-oampdu frames entirely
// - operating pdu limit is the smaller of local and peer sizes
// - information revision starts at zero, increments once per cycle changing mode, capabilities, local pdu size, vendor identifier or phy unidirectional status
// - identical peer revision lets parsing of the peer tlv be skipped
// - discovery state holds one of six values and is readable
// - pdu permission holds one of four values for the local entity
// - a 24-bit vendor identifier is held and reported
// - mode is active or passive and is reported
// - unidirectional capability comes from the phy status, not software
// - remote loopback capability allows entering remote loopback unless the phy is unidirectional
// - link monitoring capability enables link event interpretation
// - mib retrieval capability enables variable responses
`timescale 1ns/1ns
module los_top
  import los_pkg::*;
(
  // ahb-lite
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // phy status
  input  wire logic        phy_unidir,
  // transmit path from higher sublayer
  input  wire logic        tx_valid,
  input  wire logic [9:0]  tx_data,
  input  wire logic        tx_oam,
  output logic             tx_ready,
  // receive path from lower sublayer
  input  wire logic        rx_valid,
  input  wire logic [9:0]  rx_data,
  input  wire logic        rx_oam,
  input  wire logic        rx_peer_info,
  input  wire logic [7:0]  rx_peer_rev,
  input  wire logic        rx_link_event,
  input  wire logic        rx_var_req,
  output logic             rx_ready,
  // toward lower sublayer
  output logic             down_valid,
  output logic [9:0]       down_data,
  input  wire logic        down_ready,
  // toward higher sublayer
  output logic             up_valid,
  output logic [9:0]       up_data,
  // toward oam client
  output logic             oam_valid,
  output logic [9:0]       oam_data,
  output logic             oam_peer_skip,
  output logic             oam_link_event,
  output logic             oam_var_resp,
  output logic             oam_rlb_ok
);

  typedef struct packed {
    logic [31:0] hrdata;
    logic        dph;
    logic        dwr;
    logic [7:0]  daddr;
    logic        mode;
    logic        lb_cap;
    logic        lm_cap;
    logic        mib_cap;
    los_mux_t    mux;
    los_par_t    par;
    los_perm_t   perm;
    los_disc_t   disc;
    logic [15:0] mtu;
    logic [23:0] oui;
    logic [15:0] rev;
    logic [15:0] peer_max;
    logic [7:0]  peer_rev;
    logic        peer_rev_ok;
    logic [15:0] drop_cnt;
    logic        up_valid;
    logic [9:0]  up_data;
    logic        oam_valid;
    logic [9:0]  oam_data;
    logic        skip;
    logic        lev;
    logic        vresp;
    logic        unidir;
    logic        rlb;
  } los_st_t;

  los_st_t s_q;
  los_st_t s_d;

  logic       f_in_valid;
  logic       f_in_ready;
  logic [9:0] f_in_data;
  logic       lb_take;
  logic       tx_take;

  function automatic logic [15:0] los_min16(input logic [15:0] a, input logic [15:0] b);
    los_min16 = (a < b) ? a : b;
  endfunction

  // receive loopback has priority on the downward fifo
  assign lb_take    = rx_valid && !rx_oam && (s_q.par == LOS_PAR_LB);
  assign tx_take    = tx_valid && (tx_oam || (s_q.mux == LOS_MUX_FWD)) && !lb_take;
  assign f_in_valid = lb_take || tx_take;
  assign f_in_data  = lb_take ? rx_data : tx_data;
  assign rx_ready   = !lb_take || f_in_ready;
  assign tx_ready   = (tx_oam || s_q.mux == LOS_MUX_FWD) ? (f_in_ready && !lb_take) : 1'b1;

  los_fifo #(.W(LOS_FIFO_W), .D(LOS_FIFO_D)) u_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (down_valid),
    .out_ready (down_ready),
    .out_data  (down_data)
  );

  always_comb begin
    logic        ap;
    logic        changed;
    logic [31:0] w;
    s_d     = s_q;
    ap      = hsel && hready && htrans[1];
    changed = 1'b0;
    w       = hwdata;
    s_d.dph = ap;
    s_d.dwr = ap && hwrite;
    s_d.daddr = haddr[7:0];
    s_d.unidir = phy_unidir;
    if (s_q.unidir != phy_unidir) begin
      changed = 1'b1;
    end
    if (s_q.dwr) begin
      unique case (s_q.daddr)
        LOS_OFF_CTRL: begin
          s_d.mode    = w[LOS_CTL_MODE];
          s_d.lb_cap  = w[LOS_CTL_LB];
          s_d.lm_cap  = w[LOS_CTL_LM];
          s_d.mib_cap = w[LOS_CTL_MIB];
          s_d.mux     = los_mux_t'(w[LOS_CTL_MUX]);
          s_d.par     = (w[LOS_CTL_PAR+1:LOS_CTL_PAR] == 2'b11) ? LOS_PAR_DIS
                        : los_par_t'(w[LOS_CTL_PAR+1:LOS_CTL_PAR]);
          s_d.perm    = los_perm_t'(w[LOS_CTL_PERM+1:LOS_CTL_PERM]);
          s_d.disc    = (w[LOS_CTL_DISC+2:LOS_CTL_DISC] > 3'h5) ? LOS_DSC_FAULT
                        : los_disc_t'(w[LOS_CTL_DISC+2:LOS_CTL_DISC]);
          changed     = changed ||
                        (w[3:0] != {s_q.mib_cap, s_q.lm_cap, s_q.lb_cap, s_q.mode});
        end
        LOS_OFF_MTU: begin
          s_d.mtu = w[15:0];
          changed = changed || (w[15:0] != s_q.mtu);
        end
        LOS_OFF_OUI: begin
          s_d.oui = w[23:0];
          changed = changed || (w[23:0] != s_q.oui);
        end
        LOS_OFF_PEER: begin
          s_d.peer_max = w[15:0];
        end
        default: begin
        end
      endcase
    end
    if (changed) begin
      s_d.rev = s_q.rev + 16'h0001;
    end
    // receive steering
    s_d.up_valid  = rx_valid && !rx_oam && (s_q.par == LOS_PAR_FWD);
    s_d.up_data   = rx_data;
    s_d.oam_valid = rx_valid && rx_oam;
    s_d.oam_data  = rx_data;
    if (rx_valid && !rx_oam && (s_q.par == LOS_PAR_DIS) && (s_q.drop_cnt != 16'hffff)) begin
      s_d.drop_cnt = s_q.drop_cnt + 16'h0001;
    end
    s_d.skip = 1'b0;
    if (rx_peer_info) begin
      s_d.skip        = s_q.peer_rev_ok && (rx_peer_rev == s_q.peer_rev);
      s_d.peer_rev    = rx_peer_rev;
      s_d.peer_rev_ok = 1'b1;
    end
    s_d.lev   = rx_link_event && s_q.lm_cap;
    s_d.vresp = rx_var_req && s_q.mib_cap;
    s_d.rlb   = s_d.lb_cap && !s_d.unidir;
    // read data
    s_d.hrdata = 32'h0000_0000;
    if (ap && !hwrite) begin
      unique case (haddr[7:0])
        LOS_OFF_CTRL: begin
          s_d.hrdata[LOS_CTL_MODE] = s_q.mode;
          s_d.hrdata[LOS_CTL_LB]   = s_q.lb_cap;
          s_d.hrdata[LOS_CTL_LM]   = s_q.lm_cap;
          s_d.hrdata[LOS_CTL_MIB]  = s_q.mib_cap;
          s_d.hrdata[LOS_CTL_MUX]  = s_q.mux;
          s_d.hrdata[LOS_CTL_PAR+1:LOS_CTL_PAR]   = s_q.par;
          s_d.hrdata[LOS_CTL_PERM+1:LOS_CTL_PERM] = s_q.perm;
          s_d.hrdata[LOS_CTL_DISC+2:LOS_CTL_DISC] = s_q.disc;
        end
        LOS_OFF_STATUS: begin
          s_d.hrdata[0]   = s_q.unidir;
          s_d.hrdata[1]   = s_q.lb_cap && !s_q.unidir;
          s_d.hrdata[6:4] = s_q.disc;
        end
        LOS_OFF_MTU:  s_d.hrdata = {los_min16(s_q.mtu, s_q.peer_max), s_q.mtu};
        LOS_OFF_OUI:  s_d.hrdata[23:0] = s_q.oui;
        LOS_OFF_REV:  s_d.hrdata = {8'h00, s_q.peer_rev, s_q.rev};
        LOS_OFF_PEER: s_d.hrdata[15:0] = s_q.peer_max;
        LOS_OFF_CNT:  s_d.hrdata[15:0] = s_q.drop_cnt;
        default:      s_d.hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q          <= '0;
      s_q.mux      <= LOS_MUX_FWD;
      s_q.par      <= LOS_PAR_FWD;
      s_q.perm     <= los_perm_t'(LOS_CTRL_RST[LOS_CTL_PERM+1:LOS_CTL_PERM]);
      s_q.disc     <= LOS_DSC_FAULT;
      s_q.mtu      <= LOS_MTU_RST;
      s_q.oui      <= LOS_OUI_RST;
      s_q.peer_max <= LOS_PEER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata         = s_q.hrdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign up_valid       = s_q.up_valid;
  assign up_data        = s_q.up_data;
  assign oam_valid      = s_q.oam_valid;
  assign oam_data       = s_q.oam_data;
  assign oam_peer_skip  = s_q.skip;
  assign oam_link_event = s_q.lev;
  assign oam_var_resp   = s_q.vresp;
  assign oam_rlb_ok     = s_q.rlb;

  chk_up_steer: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_valid && !rx_oam && s_q.par == LOS_PAR_FWD) |=> up_valid)
    else $error("forwarded frame not delivered up");
  chk_dis_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.par == LOS_PAR_DIS) |=> !up_valid)
    else $error("discarding parser delivered a frame");
  chk_oam_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_valid && rx_oam) |=> oam_valid)
    else $error("oampdu not handed to client");
  chk_mux_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.mux == LOS_MUX_DIS && !tx_oam && !lb_take) |-> !f_in_valid)
    else $error("discarding mux forwarded a frame");
  chk_lb_down: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_valid && !rx_oam && s_q.par == LOS_PAR_LB) |-> f_in_valid && f_in_data == rx_data)
    else $error("loopback frame not returned down");
  chk_rev_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.rev != $past(s_q.rev)) |-> s_q.rev == $past(s_q.rev) + 16'h0001)
    else $error("revision moved by other than one");
  chk_disc_legal: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.disc <= LOS_DSC_ANY)
    else $error("discovery state out of range");
  chk_lm_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    oam_link_event |-> $past(rx_link_event) && $past(s_q.lm_cap))
    else $error("link event without capability");
  chk_unidir_phy: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.unidir == $past(phy_unidir))
    else $error("unidirectional flag not from phy");
  chk_var_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    oam_var_resp |-> $past(rx_var_req) && $past(s_q.mib_cap))
    else $error("variable response without capability");
  chk_skip_same: assert property (@(posedge hclk) disable iff (!hresetn)
    oam_peer_skip |-> $past(rx_peer_info) && $past(s_q.peer_rev_ok)
      && ($past(rx_peer_rev) == $past(s_q.peer_rev)))
    else $error("peer skip on a changed revision");
endmodule // los_top

// ===== testbench/los_peer_model.sv
// Purpose: peer side of the link, feeds received words and sinks down words
// Assumes: hclk domain, a word is taken on valid and ready at a rising edge
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ns
module los_peer_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // toward the block
  output logic            rx_valid,
  output logic [9:0]      rx_data,
  output logic            rx_oam,
  output logic            rx_peer_info,
  output logic [7:0]      rx_peer_rev,
  output logic            rx_link_event,
  output logic            rx_var_req,
  input  wire logic       rx_ready,
  // from the block
  input  wire logic       down_valid,
  input  wire logic [9:0] down_data,
  output logic            down_ready
);
  logic [9:0] got[$];
  logic       stall = 1'b0;
  initial begin
    {rx_valid, rx_oam, rx_peer_info, rx_link_event, rx_var_req} = 5'h00;
    rx_data = 10'h3ff;
    rx_peer_rev = 8'hff;
    down_ready = 1'b1;
  end
  // word sink, stalls on request
  always @(posedge hclk) begin
    down_ready <= ~stall;
    if (hresetn === 1'b1 && down_valid === 1'b1 && down_ready === 1'b1) begin
      got.push_back(down_data);
    end
  end
  task send(input logic [9:0] d, input logic oam);
    @(posedge hclk);
    rx_valid <= 1'b1;
    rx_data  <= d;
    rx_oam   <= oam;
    do @(posedge hclk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_data  <= ~d;
    rx_oam   <= 1'b0;
  endtask
  // one-cycle notice: 0 peer info, 1 link event, 2 variable request
  task notice(input int k, input logic [7:0] rev);
    @(posedge hclk);
    rx_peer_info  <= (k == 0);
    rx_peer_rev   <= rev;
    rx_link_event <= (k == 1);
    rx_var_req    <= (k == 2);
    @(posedge hclk);
    {rx_peer_info, rx_link_event, rx_var_req} <= 3'h0;
    rx_peer_rev <= ~rev;
  endtask
endmodule // los_peer_model

// ===== testbench/link_oam_sublayer_status_tb_top.sv
// Purpose: register and frame steering tests of the sublayer status block
// Assumes: zero-wait ahb-lite slave, peer model on the link side
// Notes:   counters watch the upward and client outputs
`timescale 1ns/1ns
module link_oam_sublayer_status_tb_top
  import los_pkg::*;
  ;
  logic        hclk, hresetn, hsel, hwrite, hready, phy_unidir, tx_valid, tx_oam;
  logic [31:0] haddr, hwdata, hrdata, rd, ctrl;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [9:0]  tx_data, rx_data, down_data, up_data, oam_data, last_up, last_oam;
  logic [7:0]  rx_peer_rev;
  logic        rx_valid, rx_oam, rx_peer_info, rx_link_event, rx_var_req, rx_ready;
  logic        hreadyout, hresp, tx_ready, down_valid, down_ready, up_valid, oam_valid;
  logic        oam_peer_skip, oam_link_event, oam_var_resp, oam_rlb_ok;
  int          err_count, cmp_count, cyc, n_up, n_oam, n_skip, n_evt, n_var, rev;

  assign hready = hreadyout;
  initial hclk = 1'b0;
  always #20 hclk = ~hclk;

  los_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phy_unidir(phy_unidir),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_oam(tx_oam), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_oam(rx_oam), .rx_peer_info(rx_peer_info),
    .rx_peer_rev(rx_peer_rev), .rx_link_event(rx_link_event), .rx_var_req(rx_var_req),
    .rx_ready(rx_ready), .down_valid(down_valid), .down_data(down_data),
    .down_ready(down_ready), .up_valid(up_valid), .up_data(up_data),
    .oam_valid(oam_valid), .oam_data(oam_data), .oam_peer_skip(oam_peer_skip),
    .oam_link_event(oam_link_event), .oam_var_resp(oam_var_resp), .oam_rlb_ok(oam_rlb_ok));

  los_peer_model peer (.hclk(hclk), .hresetn(hresetn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_oam(rx_oam), .rx_peer_info(rx_peer_info),
    .rx_peer_rev(rx_peer_rev), .rx_link_event(rx_link_event), .rx_var_req(rx_var_req),
    .rx_ready(rx_ready), .down_valid(down_valid), .down_data(down_data),
    .down_ready(down_ready));

  // output watchers and hang limit
  always @(posedge hclk) begin
    cyc++;
    if (up_valid === 1'b1) begin
      n_up++;
      last_up = up_data;
    end
    if (oam_valid === 1'b1) begin
      n_oam++;
      last_oam = oam_data;
    end
    if (oam_peer_skip === 1'b1) n_skip++;
    if (oam_link_event === 1'b1) n_evt++;
    if (oam_var_resp === 1'b1) n_var++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task tally_and_finish();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_cnt(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk_reg(rd & m, exp);
  endtask
  task set_ctrl(input logic [31:0] v);
    ctrl = v;
    ahb(1'b1, LOS_OFF_CTRL, v);
  endtask
  task tx(input logic [9:0] d, input logic oam);
    @(posedge hclk);
    tx_valid <= 1'b1;
    tx_data  <= d;
    tx_oam   <= oam;
    do @(posedge hclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    tx_data  <= ~d;
    tx_oam   <= 1'b0;
  endtask
  task down_chk(input int n, input logic [9:0] last);
    chk_cnt(peer.got.size(), n);
    chk_reg({22'h0, peer.got[$]}, {22'h0, last});
  endtask
  task idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  initial begin
    {hsel, hwrite, phy_unidir, tx_valid, tx_oam, hresetn} = 6'h00;
    {haddr, hwdata, htrans, hsize, tx_data} = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(LOS_OFF_CTRL, 32'hffff_ffff, LOS_CTRL_RST);
    rd_chk(LOS_OFF_MTU, 32'hffff_ffff, {LOS_MTU_RST, LOS_MTU_RST});
    rd_chk(LOS_OFF_OUI, 32'h00ff_ffff, {8'h0, LOS_OUI_RST});
    rd_chk(LOS_OFF_REV, 32'h0000_ffff, 32'h0);
    rd_chk(LOS_OFF_PEER, 32'h0000_ffff, {16'h0, LOS_PEER_RST});
    rd_chk(8'h40, 32'hffff_ffff, 32'h0);
    chk_reg({31'h0, hresp}, 32'h0);
    ahb(1'b0, LOS_OFF_CTRL, 32'h0);
    chk_cnt(rd[14:12] <= 3'h5, 1);
    set_ctrl(32'h0000_5300);
    rd_chk(LOS_OFF_STATUS, 32'h0000_0070, 32'h0000_0050);
    set_ctrl(32'h0000_6300);
    rd_chk(LOS_OFF_CTRL, 32'h0000_7000, 32'h0);
    for (int p = 0; p < 4; p++) begin
      set_ctrl({LOS_CTRL_RST[31:10], 2'(p), LOS_CTRL_RST[7:0]});
      rd_chk(LOS_OFF_CTRL, 32'h0000_0300, {22'h0, 2'(p), 8'h0});
    end
    // caps off: notices must not reach the client
    peer.notice(1, 8'h00);
    peer.notice(2, 8'h00);
    idle(3);
    chk_cnt(n_evt, 0);
    chk_cnt(n_var, 0);
    chk_reg({31'h0, oam_rlb_ok}, 32'h0);
    // mode then each cap, one write each
    for (int b = 0; b < 4; b++) begin
      set_ctrl(ctrl | (32'h1 << b));
      rev++;
      rd_chk(LOS_OFF_REV, 32'h0000_ffff, rev);
    end
    rd_chk(LOS_OFF_CTRL, 32'h1, 32'h1);
    peer.notice(1, 8'h00);
    peer.notice(2, 8'h00);
    idle(3);
    chk_cnt(n_evt, 1);
    chk_cnt(n_var, 1);
    chk_reg({31'h0, oam_rlb_ok}, 32'h1);
    @(posedge hclk) phy_unidir <= 1'b1;
    idle(3);
    rev++;
    chk_reg({31'h0, oam_rlb_ok}, 32'h0);
    rd_chk(LOS_OFF_REV, 32'h0000_ffff, rev);
    rd_chk(LOS_OFF_STATUS, 32'h0000_0003, 32'h1);
    @(posedge hclk) phy_unidir <= 1'b0;
    idle(3);
    rev++;
    // peer size smaller, then local size smaller
    ahb(1'b1, LOS_OFF_PEER, 32'h0000_0200);
    rd_chk(LOS_OFF_MTU, 32'hffff_0000, 32'h0200_0000);
    ahb(1'b1, LOS_OFF_MTU, 32'h0000_0100);
    rev++;
    rd_chk(LOS_OFF_MTU, 32'hffff_ffff, 32'h0100_0100);
    ahb(1'b1, LOS_OFF_OUI, 32'h00ab_cdef);
    rev++;
    rd_chk(LOS_OFF_OUI, 32'h00ff_ffff, 32'h00ab_cdef);
    rd_chk(LOS_OFF_REV, 32'h0000_ffff, rev);
    peer.notice(0, 8'h05);
    peer.notice(0, 8'h05);
    peer.notice(0, 8'h06);
    idle(3);
    chk_cnt(n_skip, 1);
    // frame steering
    tx(10'h155, 1'b0);
    idle(4);
    down_chk(1, 10'h155);
    peer.send(10'h0aa, 1'b0);
    idle(3);
    chk_cnt(n_up, 1);
    chk_reg({22'h0, last_up}, 32'h0aa);
    set_ctrl(ctrl | 32'h10);
    tx(10'h111, 1'b0);
    tx(10'h122, 1'b1);
    idle(4);
    down_chk(2, 10'h122);
    set_ctrl((ctrl & ~32'h70) | 32'h20);
    peer.send(10'h0bb, 1'b0);
    idle(4);
    down_chk(3, 10'h0bb);
    chk_cnt(n_up, 1);
    set_ctrl((ctrl & ~32'h60) | 32'h40);
    peer.send(10'h0cc, 1'b0);
    peer.send(10'h3cc, 1'b1);
    idle(4);
    down_chk(3, 10'h0bb);
    chk_cnt(n_up, 1);
    chk_cnt(n_oam, 1);
    chk_reg({22'h0, last_oam}, 32'h3cc);
    rd_chk(LOS_OFF_CNT, 32'h0000_ffff, 32'h1);
    // loopback buffer filled under stall, then drained
    set_ctrl((ctrl & ~32'h60) | 32'h20);
    peer.stall = 1'b1;
    idle(2);
    for (int i = 0; i < 8; i++) peer.send(10'h200 + 10'(i), 1'b0);
    // ninth word waits on the full buffer
    fork
      peer.send(10'h208, 1'b0);
    join_none
    idle(2);
    chk_reg({31'h0, rx_ready}, 32'h0);
    peer.stall = 1'b0;
    idle(20);
    chk_cnt(peer.got.size(), 12);
    for (int i = 0; i < 9; i++) chk_reg({22'h0, peer.got[3+i]}, 32'h200 + i);
    tally_and_finish();
  end
endmodule // link_oam_sublayer_status_tb_top
